//--- shlat_pkg.sv
package shlat_pkg;

    // geometry
    localparam int unsigned SHLAT_BITS = 64;
    localparam int unsigned SHLAT_LANES = 8;
    localparam int unsigned SHLAT_CHAIN = 8;
    localparam int unsigned SHLAT_FIFO_DEPTH = 4;
    localparam int unsigned SHLAT_FIFO_WIDTH = SHLAT_LANES + 1;
    localparam int unsigned SHLAT_SYNC_WIDTH = 16;

    // timing: internal one-shot clock against the 100 mhz system clock
    localparam int unsigned SHLAT_SYS_CLK_HZ = 100_000_000;
    localparam int unsigned SHLAT_INT_CLK_HZ = 800_000;
    localparam int unsigned SHLAT_TICK_CYCLES =
        SHLAT_SYS_CLK_HZ / SHLAT_INT_CLK_HZ;
    localparam logic [7:0] SHLAT_TICK_LAST = 8'(SHLAT_TICK_CYCLES - 1);

    // register byte offsets
    localparam logic [7:0] SHLAT_OFS_CTRL = 8'h00;
    localparam logic [7:0] SHLAT_OFS_STATUS = 8'h04;
    localparam logic [7:0] SHLAT_OFS_SHIFT_LO = 8'h08;
    localparam logic [7:0] SHLAT_OFS_SHIFT_HI = 8'h0c;
    localparam logic [7:0] SHLAT_OFS_HOLD_LO = 8'h10;
    localparam logic [7:0] SHLAT_OFS_HOLD_HI = 8'h14;

    // control fields and reset values
    localparam int unsigned SHLAT_CTRL_SOFT_EN = 0;
    localparam int unsigned SHLAT_CTRL_DRAIN_HOLD = 1;
    localparam logic SHLAT_RST_SOFT_EN = 1'b1;
    localparam logic SHLAT_RST_DRAIN_HOLD = 1'b0;

    // status fields
    localparam int unsigned SHLAT_STAT_GUARD = 0;
    localparam int unsigned SHLAT_STAT_FULL = 1;
    localparam int unsigned SHLAT_STAT_EMPTY = 2;
    localparam int unsigned SHLAT_STAT_OVF = 3;
    localparam int unsigned SHLAT_STAT_MODE = 4;

    // synchroniser bit positions
    localparam int unsigned SHLAT_SY_SCLK = 0;
    localparam int unsigned SHLAT_SY_LANE = 1;
    localparam int unsigned SHLAT_SY_MODE = 9;
    localparam int unsigned SHLAT_SY_GATE1 = 10;
    localparam int unsigned SHLAT_SY_GATE2 = 11;
    localparam int unsigned SHLAT_SY_EN_B = 12;
    localparam int unsigned SHLAT_SY_CLR_B = 13;
    localparam int unsigned SHLAT_SY_RC_LOW = 14;
    localparam int unsigned SHLAT_SY_RC_HIGH = 15;

    // ahb-lite codes
    localparam logic [1:0] SHLAT_HTRANS_NONSEQ = 2'h2;
    localparam logic SHLAT_HRESP_OKAY = 1'b0;

    // protection one-shot
    typedef enum logic [1:0] {
        SHLAT_G_ARMED,
        SHLAT_G_WAIT_TICK,
        SHLAT_G_FIRED
    } shlat_guard_t;

    typedef struct packed {
        logic [SHLAT_BITS-1:0] shift;
        logic [SHLAT_BITS-1:0] hold1;
        logic [SHLAT_BITS-1:0] hold2;
        logic [SHLAT_BITS-1:0] drv;
        shlat_guard_t guard;
        logic [7:0] tick_cnt;
        logic sclk_prev;
        logic soft_en;
        logic drain_hold;
        logic ovf;
        logic ph_valid;
        logic ph_write;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
    } shlat_state_t;

endpackage

//--- shlat_stream_if.sv
`timescale 1ns/1ns
interface shlat_stream_if #(
    parameter int unsigned WIDTH = 9
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- shlat_sync.sv
`timescale 1ns/1ns
module shlat_sync #(
    parameter int unsigned WIDTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // asynchronous levels in, agreed levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] stable
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] agreed;
    } shlat_sync_state_t;

    shlat_sync_state_t st;
    shlat_sync_state_t next_st;

    // three stages; a bit moves once stages two and three agree
    always_comb begin
        next_st = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.agreed[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign stable = st.agreed;
endmodule // shlat_sync

//--- shlat_fifo.sv
`timescale 1ns/1ns
module shlat_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // fill and drain sides
    shlat_stream_if.snk fill,
    shlat_stream_if.src drain,
    // levels
    output logic full,
    output logic empty
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] count;
    } shlat_fifo_state_t;

    shlat_fifo_state_t st;
    shlat_fifo_state_t next_st;
    logic push;
    logic pop;

    // handshakes
    assign full = (st.count == DEPTH_C);
    assign empty = (st.count == '0);
    assign fill.ready = !full;
    assign drain.valid = !empty;
    assign drain.data = st.mem[st.rp];
    assign push = fill.valid && !full;
    assign pop = drain.ready && !empty;

    // pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = fill.data;
            next_st.wp = (st.wp == LAST_C) ? '0 : st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = (st.rp == LAST_C) ? '0 : st.rp + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // shlat_fifo

//--- shlat_head_driver.sv
`timescale 1ns/1ns
// Behaviour
// R1 - one 64-bit shift register feeds two 64-bit latches that steer 64 drivers.
// R2 - the shift register advances on the controller's shift clock.
// R3 - mode high loads eight 8-bit chains from eight lanes, low one 64-bit chain.
// R4 - a high data bit means its driver is on, a low bit means off.
// R5 - bit 63 of the shift register is presented on the tail output.
// R6 - each latch follows its input while its gate is high and holds while low.
// R7 - drivers may turn on while the enable input is low, its idle level.
// R8 - a low clear input empties shift register and both latches.
// R9 - drivers are open-drain: pull low when on, float when off.
// R10 - the guard output falls at the first internal tick after rc is low.
// R11 - the guard output rises again once the rc node is back above high.
// R12 - the controller leaves the capacitor enough discharge time between cycles.
// R13 - on a shift clock rise each chain's first stage takes data, others shift.
// R14 - a driver is on only if latched high, enabled and the guard not expired.
module shlat_head_driver (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // controller pins
    input wire logic shift_clk,
    input wire logic [shlat_pkg::SHLAT_LANES-1:0] lane_data_in,
    input wire logic mode_sel,
    input wire logic first_hold_gate,
    input wire logic second_hold_gate,
    input wire logic out_enable_b,
    input wire logic clear_b,
    output logic link_ready,
    // rc timing node comparator levels
    input wire logic rc_timing_node_low,
    input wire logic rc_timing_node_high,
    // head side
    output logic [shlat_pkg::SHLAT_BITS-1:0] driver_outputs_out,
    output logic [shlat_pkg::SHLAT_BITS-1:0] driver_outputs_oe,
    output logic last_stage_bit,
    output logic guard_timer_out
);
    import shlat_pkg::*;

    // notes on timing
    // pins are sampled by clk through three stages
    // a pin pulse under two clocks may be lost
    // lanes and mode are taken with the agreed edge
    // so they must stand a few clocks around it
    // a shift edge that meets a full fifo is lost
    // and leaves the overflow flag set
    // latches are clocked copies, one cycle behind
    // drivers follow latch two one cycle later
    // clear wins over a shift in the same cycle
    // the guard tick runs free from reset
    // so the fall comes up to one tick late
    // bus reads return the state at address time
    // writes take effect after the data phase
    // unmapped offsets read zero, writes ignored
    // the guard state is also read back in status
    // drain_hold stalls the fifo drain for test
    // soft_en gates all drivers from software
    // hreadyout is constant: no wait states
    // hresp is constant okay
    // link_ready drops while the fifo is full
    // the controller owns discharge time of the node
    // hsize is ignored: word access only
    // haddr bits above 7 are ignored
    // bits 1:0 of the address are forced to zero

    // whole block state and its next value
    shlat_state_t st;
    shlat_state_t next_st;

    // synchroniser in and out
    logic [SHLAT_SYNC_WIDTH-1:0] raw;
    logic [SHLAT_SYNC_WIDTH-1:0] sy;

    // fifo levels, edge and bus helpers
    logic fifo_full;
    logic fifo_empty;
    logic sclk_rise;
    logic ph_take;
    logic [31:0] rd_mux;

    shlat_stream_if #(.WIDTH(SHLAT_FIFO_WIDTH)) fill_if ();
    shlat_stream_if #(.WIDTH(SHLAT_FIFO_WIDTH)) drain_if ();

    // one step of the register in either loading mode
    function automatic logic [SHLAT_BITS-1:0] shift_step(
        input logic [SHLAT_BITS-1:0] cur,
        input logic [SHLAT_LANES-1:0] lanes,
        input logic parallel
    );
        logic [SHLAT_BITS-1:0] res;
        // serial: whole register moves by one
        res = {cur[SHLAT_BITS-2:0], lanes[0]};
        // parallel: eight chains of eight
        if (parallel) begin
            for (int k = 0; k < SHLAT_LANES; k++) begin
                res[k*SHLAT_CHAIN] = lanes[k];
                for (int j = 1; j < SHLAT_CHAIN; j++) begin
                    res[k*SHLAT_CHAIN+j] = cur[k*SHLAT_CHAIN+j-1];
                end
            end
        end
        return res;
    endfunction

    // register read decode
    function automatic logic [31:0] reg_read(
        input shlat_state_t s,
        input logic [7:0] addr,
        input logic [SHLAT_SYNC_WIDTH-1:0] lv,
        input logic full,
        input logic empty
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (addr)
            SHLAT_OFS_CTRL: begin
                v[SHLAT_CTRL_SOFT_EN] = s.soft_en;
                v[SHLAT_CTRL_DRAIN_HOLD] = s.drain_hold;
            end
            SHLAT_OFS_STATUS: begin
                // status bit 0 mirrors the guard output
                v[SHLAT_STAT_GUARD] = (s.guard != SHLAT_G_FIRED);
                v[SHLAT_STAT_FULL] = full;
                v[SHLAT_STAT_EMPTY] = empty;
                v[SHLAT_STAT_OVF] = s.ovf;
                v[SHLAT_STAT_MODE] = lv[SHLAT_SY_MODE];
            end
            SHLAT_OFS_SHIFT_LO: v = s.shift[31:0];
            SHLAT_OFS_SHIFT_HI: v = s.shift[63:32];
            SHLAT_OFS_HOLD_LO: v = s.hold2[31:0];
            SHLAT_OFS_HOLD_HI: v = s.hold2[63:32];
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // pin inputs through the three-stage synchroniser
    assign raw = {rc_timing_node_high, rc_timing_node_low, clear_b,
                  out_enable_b, second_hold_gate, first_hold_gate,
                  mode_sel, lane_data_in, shift_clk};

    shlat_sync #(.WIDTH(SHLAT_SYNC_WIDTH)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(raw),
        .stable(sy)
    );

    // R2 shift clock edge
    assign sclk_rise = sy[SHLAT_SY_SCLK] && !st.sclk_prev;

    // capture lanes and mode at each shift clock rise
    assign fill_if.valid = sclk_rise;
    assign fill_if.data = {sy[SHLAT_SY_MODE],
                           sy[SHLAT_SY_LANE +: SHLAT_LANES]};
    assign drain_if.ready = !st.drain_hold && sy[SHLAT_SY_CLR_B];
    assign link_ready = fill_if.ready;

    shlat_fifo #(
        .WIDTH(SHLAT_FIFO_WIDTH),
        .DEPTH(SHLAT_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .fill(fill_if.snk),
        .drain(drain_if.src),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    // bus handshake: zero wait, always okay
    assign hreadyout = 1'b1;
    assign hresp = SHLAT_HRESP_OKAY;
    assign hrdata = st.rdata;
    assign ph_take = hsel && hready && (htrans == SHLAT_HTRANS_NONSEQ);
    assign rd_mux = reg_read(st, {haddr[7:2], 2'b00}, sy, fifo_full,
                             fifo_empty);

    // next state of the whole block
    always_comb begin
        next_st = st;
        next_st.sclk_prev = sy[SHLAT_SY_SCLK];

        // R13 chains advance from the fifo
        if (drain_if.valid && drain_if.ready) begin
            // R3 mode picks chain layout
            next_st.shift = shift_step(st.shift,
                drain_if.data[SHLAT_LANES-1:0],
                drain_if.data[SHLAT_LANES]);
        end

        // R1 two latch stages in series
        // R6 transparent while gate high
        if (sy[SHLAT_SY_GATE1]) begin
            next_st.hold1 = st.shift;
        end
        if (sy[SHLAT_SY_GATE2]) begin
            next_st.hold2 = st.hold1;
        end

        // R8 clear pin empties data path
        if (!sy[SHLAT_SY_CLR_B]) begin
            next_st.shift = '0;
            next_st.hold1 = '0;
            next_st.hold2 = '0;
        end

        // internal one-shot clock divider
        // free-running, independent of the rc node
        next_st.tick_cnt = (st.tick_cnt == SHLAT_TICK_LAST) ?
                           8'h00 : st.tick_cnt + 8'h01;

        // R10 fall on internal tick after rc low
        unique case (st.guard)
            SHLAT_G_ARMED: begin
                // wait for a synchronised rc low
                if (sy[SHLAT_SY_RC_LOW]) begin
                    next_st.guard = SHLAT_G_WAIT_TICK;
                end
            end
            SHLAT_G_WAIT_TICK: begin
                // fall only on an internal tick
                if (st.tick_cnt == SHLAT_TICK_LAST) begin
                    next_st.guard = SHLAT_G_FIRED;
                end
            end
            SHLAT_G_FIRED: begin
                // R11 recharge rearms
                if (sy[SHLAT_SY_RC_HIGH]) begin
                    next_st.guard = SHLAT_G_ARMED;
                end
            end
            default: next_st.guard = SHLAT_G_ARMED;
        endcase

        // R14 latched, enabled and guard alive
        // R7 enable low lets drivers on
        // R4 high bit means on
        // registered so the drivers never glitch
        next_st.drv = st.hold2 & {SHLAT_BITS{!sy[SHLAT_SY_EN_B]
            && (st.guard != SHLAT_G_FIRED) && st.soft_en}};


        // address phase capture and read data
        next_st.ph_valid = ph_take;
        if (ph_take) begin
            next_st.ph_write = hwrite;
            next_st.ph_addr = {haddr[7:2], 2'b00};
            if (!hwrite) begin
                // read data latched at address time
                next_st.rdata = rd_mux;
            end
        end

        // data phase writes
        if (st.ph_valid && st.ph_write) begin
            if (st.ph_addr == SHLAT_OFS_CTRL) begin
                next_st.soft_en = hwdata[SHLAT_CTRL_SOFT_EN];
                next_st.drain_hold = hwdata[SHLAT_CTRL_DRAIN_HOLD];
            end
            // status is read-only but for the overflow bit
            if (st.ph_addr == SHLAT_OFS_STATUS &&
                hwdata[SHLAT_STAT_OVF]) begin
                next_st.ovf = 1'b0;
            end
        end

        // overflow sticky, set wins over clear
        if (sclk_rise && !fill_if.ready) begin
            next_st.ovf = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= '0;
            // soft_en resets high; guard and drain_hold are set to their zero resets
            st.guard <= SHLAT_G_ARMED;
            st.soft_en <= SHLAT_RST_SOFT_EN;
            st.drain_hold <= SHLAT_RST_DRAIN_HOLD;
        end else begin
            st <= next_st;
        end
    end

    // R9 open-drain: pull low when on
    assign driver_outputs_out = '0;
    assign driver_outputs_oe = st.drv;
    // R5 cascade tail
    assign last_stage_bit = st.shift[SHLAT_BITS-1];

    // guard pin high while the one-shot is alive
    assign guard_timer_out = (st.guard != SHLAT_G_FIRED);
endmodule // shlat_head_driver

//--- shlat_head_driver_properties.sv
`timescale 1ns/1ns
module shlat_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pins watched
    input wire logic out_enable_b,
    input wire logic clear_b,
    input wire logic rc_timing_node_low,
    input wire logic rc_timing_node_high,
    input wire logic [shlat_pkg::SHLAT_BITS-1:0] driver_outputs_out,
    input wire logic [shlat_pkg::SHLAT_BITS-1:0] driver_outputs_oe,
    input wire logic last_stage_bit,
    input wire logic guard_timer_out
);
    import shlat_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // steps held long enough to pass the synchroniser
    sequence s_en_off;
        out_enable_b[*8];
    endsequence
    sequence s_clr;
        (!clear_b)[*8];
    endsequence
    sequence s_no_high;
        (!rc_timing_node_high)[*5];
    endsequence
    property p_rst_out;
        $rose(rst_b) |-> driver_outputs_oe == '0 && !last_stage_bit;
    endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("outputs not cleared by reset");
    property p_open_drain;
        driver_outputs_out == '0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("driver pull level not low");
    property p_en_off;
        s_en_off |-> driver_outputs_oe == '0;
    endproperty
    a_en_off: assert property (p_en_off)
        else $error("drivers on while disabled");
    property p_clr;
        s_clr |-> driver_outputs_oe == '0 && !last_stage_bit;
    endproperty
    a_clr: assert property (p_clr)
        else $error("clear did not empty the chain");
    property p_guard_oe;
        (!guard_timer_out)[*3] |-> driver_outputs_oe == '0;
    endproperty
    a_guard_oe: assert property (p_guard_oe)
        else $error("drivers on after guard expired");
    property p_fall;
        $rose(rc_timing_node_low) |-> ##[1:140] !guard_timer_out;
    endproperty
    a_fall: assert property (p_fall)
        else $error("guard did not fall after rc low");
    property p_rise;
        $rose(rc_timing_node_high) |-> ##[1:8] guard_timer_out;
    endproperty
    a_rise: assert property (p_rise)
        else $error("guard did not rise after rc high");
    property p_hold;
        s_no_high ##0 !guard_timer_out |=> !guard_timer_out;
    endproperty
    a_hold: assert property (p_hold)
        else $error("guard rose without rc high");
endmodule // shlat_chk
bind shlat_head_driver shlat_chk u_chk (.clk(clk), .rst_b(rst_b),
    .out_enable_b(out_enable_b), .clear_b(clear_b),
    .rc_timing_node_low(rc_timing_node_low),
    .rc_timing_node_high(rc_timing_node_high),
    .driver_outputs_out(driver_outputs_out),
    .driver_outputs_oe(driver_outputs_oe),
    .last_stage_bit(last_stage_bit), .guard_timer_out(guard_timer_out));

//--- shlat_ctrl_model.sv
`timescale 1ns/1ns
module shlat_ctrl_model (
    // system clock
    input wire logic clk,
    // controller pins
    output logic shift_clk,
    output logic [shlat_pkg::SHLAT_LANES-1:0] lane_data_in,
    output logic mode_sel
);
    import shlat_pkg::*;
    localparam int HALF = 8; // half of a 160 ns link period
    // idle levels at time zero
    initial begin
        shift_clk = 1'b0;
        lane_data_in = '0;
        mode_sel = 1'b0;
    end
    // send n edges, last bit of each chain first
    task automatic load(input logic [63:0] v, input logic par, input int n);
        logic [7:0] l;
        for (int j = 0; j < n; j++) begin
            @(posedge clk);
            for (int k = 0; k < 8; k++)
                l[k] = par ? v[8*k+7-j] : v[63-j];
            mode_sel <= par;
            lane_data_in <= l;
            repeat (HALF - 1) @(posedge clk);
            shift_clk <= 1'b1;
            repeat (HALF) @(posedge clk);
            shift_clk <= 1'b0;
        end
        // released lanes show the inverse, clock stands still
        @(posedge clk);
        lane_data_in <= ~lane_data_in;
    endtask
endmodule // shlat_ctrl_model

//--- shift_latch_head_driver_bench.sv
`timescale 1ns/1ns
module shift_latch_head_driver_bench;
    import shlat_pkg::*;
    localparam logic [63:0] P = 64'hc3a5_0f1e_2d3c_4b5a;
    localparam logic [63:0] Q = 64'h1e2d_3c4b_5a69_7887;
    logic clk, rst_b, hsel, hwrite, g1, g2, en_b, clr_b, rcl, rch;
    logic hreadyout, hresp, sclk, mode, link_ready, tail, guard;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] lanes;
    logic [63:0] oe, od;
    int mismatches, num_checks, cycles;

    shlat_head_driver uut (.clk(clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .shift_clk(sclk),
        .lane_data_in(lanes), .mode_sel(mode), .first_hold_gate(g1),
        .second_hold_gate(g2), .out_enable_b(en_b), .clear_b(clr_b),
        .link_ready(link_ready), .rc_timing_node_low(rcl),
        .rc_timing_node_high(rch), .driver_outputs_out(od),
        .driver_outputs_oe(oe), .last_stage_bit(tail),
        .guard_timer_out(guard));
    shlat_ctrl_model ctrl (.clk(clk), .shift_clk(sclk),
        .lane_data_in(lanes), .mode_sel(mode));

    // system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one ahb-lite single word transfer
    task automatic bus(input logic wr, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] r);
        @(posedge clk);
        htrans <= SHLAT_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, rd);
        check(64'(rd), 64'(e));
    endtask
    task automatic r64(input logic [7:0] a, output logic [63:0] v);
        logic [31:0] hi;
        bus(1'b0, a, 32'h0, rd);
        bus(1'b0, a + 8'h4, 32'h0, hi);
        v = {hi, rd};
    endtask
    task automatic latch(input logic a, input logic b);
        @(posedge clk);
        g1 <= a;
        g2 <= b;
        idle(8);
        g1 <= 1'b0;
        g2 <= 1'b0;
        idle(8);
    endtask

    task automatic t_reset;
        check(oe, '0);
        check(od, '0);
        check(64'(tail), 64'h0);
        check(64'(hresp), 64'h0);
        rchk(SHLAT_OFS_CTRL, 32'h1);
        rchk(SHLAT_OFS_STATUS, 32'h5);
        rchk(8'h40, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_serial;
        logic [63:0] v;
        ctrl.load(P, 1'b0, 64);
        idle(8);
        r64(SHLAT_OFS_SHIFT_LO, v);
        check(v, P);
        check(64'(tail), 64'(P[63]));
        latch(1'b1, 1'b1);
        r64(SHLAT_OFS_HOLD_LO, v);
        check(v, P);
        check(oe, P);
        $display("test serial done");
    endtask
    task automatic t_parallel;
        logic [63:0] v;
        ctrl.load(Q, 1'b1, 8);
        idle(8);
        r64(SHLAT_OFS_SHIFT_LO, v);
        check(v, Q);
        check(oe, P);
        latch(1'b1, 1'b0);
        check(oe, P);
        latch(1'b0, 1'b1);
        check(oe, Q);
        $display("test parallel done");
    endtask
    task automatic t_enable;
        @(posedge clk);
        en_b <= 1'b1;
        idle(8);
        check(oe, '0);
        en_b <= 1'b0;
        idle(8);
        check(oe, Q);
        bus(1'b1, SHLAT_OFS_CTRL, 32'h0, rd);
        idle(4);
        check(oe, '0);
        bus(1'b1, SHLAT_OFS_CTRL, 32'h1, rd);
        idle(4);
        check(oe, Q);
        $display("test enable done");
    endtask
    task automatic t_guard;
        int n;
        @(posedge clk);
        rcl <= 1'b1;
        n = 0;
        while (guard !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check(64'(n < 140), 64'h1);
        idle(4);
        check(oe, '0);
        rchk(SHLAT_OFS_STATUS, 32'h14);
        // one full tick of discharge time
        idle(SHLAT_TICK_CYCLES);
        rcl <= 1'b0;
        idle(4);
        rch <= 1'b1;
        idle(8);
        check(64'(guard), 64'h1);
        idle(4);
        check(oe, Q);
        rch <= 1'b0;
        $display("test guard done");
    endtask
    task automatic t_fifo;
        bus(1'b1, SHLAT_OFS_CTRL, 32'h3, rd);
        ctrl.load(64'h0, 1'b0, 5);
        idle(8);
        check(64'(link_ready), 64'h0);
        rchk(SHLAT_OFS_STATUS, 32'hb);
        bus(1'b1, SHLAT_OFS_CTRL, 32'h1, rd);
        bus(1'b1, SHLAT_OFS_STATUS, 32'h8, rd);
        idle(8);
        rchk(SHLAT_OFS_STATUS, 32'h5);
        check(64'(link_ready), 64'h1);
        $display("test fifo done");
    endtask
    task automatic t_clear;
        logic [63:0] v;
        @(posedge clk);
        clr_b <= 1'b0;
        idle(8);
        clr_b <= 1'b1;
        idle(8);
        r64(SHLAT_OFS_SHIFT_LO, v);
        check(v, '0);
        r64(SHLAT_OFS_HOLD_LO, v);
        check(v, '0);
        check(oe, '0);
        $display("test clear done");
    endtask

    // main sequence
    initial begin
        rst_b = 1'b0;
        hsel = 1'b1;
        htrans = 2'h0;
        haddr = '0;
        hwrite = 1'b0;
        hwdata = '0;
        {g1, g2, en_b, rcl, rch} = '0;
        clr_b = 1'b1;
        mismatches = 0;
        num_checks = 0;
        cycles = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        idle(8);
        t_reset;
        t_serial;
        t_parallel;
        t_enable;
        t_guard;
        t_fifo;
        t_clear;
        end_of_test;
    end

    // hang limit
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test;
        end
    end
endmodule // shift_latch_head_driver_bench
